// ===== inc/fbdac_map.svh
// register map, field positions and reset values of the five-bit converter control block
// Operation
// [RULE1] Control bit 7 turns the converter on when 1 and off when 0.
// [RULE2] The level code picks one of thirty-two levels: negative source plus span times code over 32.
// [RULE3] The level code sits in bits 4 down to 0 of the level register.
// [RULE4] Control bit 5 connects the converter output to pin A when 1 and disconnects it when 0.
// [RULE5] Control bit 4 connects the converter output to pin B when 1 and disconnects it when 0.
// [RULE6] Control bits 3:2 pick the positive source: 00 analog supply, 01 positive reference pin, 10 buffer, 11 reserved.
// [RULE7] Control bit 0 picks the negative source: 1 negative reference pin, 0 analog ground.
// [RULE8] A pin carrying the converter voltage has its digital driver, weak pull-up and input detector forced off.
// [RULE9] A digital read of a pin carrying the converter voltage always returns zero.
// [RULE10] The converter keeps running in sleep and a wake-up leaves the control register unchanged.
// [RULE11] Device reset disables the converter, disconnects both pins and clears the level code.
// [RULE12] Unimplemented control bits 6 and 1 and level bits 7 to 5 read zero and ignore writes.
`ifndef FBDAC_MAP_SVH
`define FBDAC_MAP_SVH

`define FBDAC_CTRL_IDX 12'hF33
`define FBDAC_LEVEL_IDX 12'hF34
`define FBDAC_ADDR_W 14
`define FBDAC_CTRL_ADDR 14'h3CCC
`define FBDAC_LEVEL_ADDR 14'h3CD0

`define FBDAC_EN_BIT 7
`define FBDAC_OEA_BIT 5
`define FBDAC_OEB_BIT 4
`define FBDAC_PSS_HI 3
`define FBDAC_PSS_LO 2
`define FBDAC_NSS_BIT 0
`define FBDAC_CTRL_MASK 8'hBD
`define FBDAC_LEVEL_MASK 8'h1F
`define FBDAC_CTRL_RST 8'h00
`define FBDAC_LEVEL_RST 5'h00
`define FBDAC_LEVEL_STEPS 6'h20

`define FBDAC_PSS_SUPPLY 2'h0
`define FBDAC_PSS_VREFP 2'h1
`define FBDAC_PSS_BUFFER 2'h2

`define FBDAC_HTRANS_NONSEQ_BIT 1

`endif

// ===== inc/fbdac_pkg.sv
// types shared by the five-bit converter control block
package fbdac_pkg;

  typedef struct packed {
    logic enable;
    logic pin_a_output_enable;
    logic pin_b_output_enable;
    logic [1:0] positive_source_select;
    logic negative_source_select;
  } fbdac_ctrl_t;

  typedef enum logic [1:0] {
    FBDAC_POS_SUPPLY,
    FBDAC_POS_VREFP,
    FBDAC_POS_BUFFER,
    FBDAC_POS_NONE
  } fbdac_pos_t;

  typedef struct packed {
    logic driver_off;
    logic pullup_off;
    logic detector_off;
    logic read_zero;
  } fbdac_pin_ovr_t;

  typedef struct packed {
    logic enable;
    fbdac_pos_t pos_src;
    logic neg_vrefm;
    logic [4:0] level_code;
  } fbdac_analog_t;

endpackage

// ===== src/fbdac_pin_override.sv
// per-pin override for a pin routed to the converter voltage
`timescale 1ns/1ps
`include "fbdac_map.svh"
module fbdac_pin_override (
  input wire logic route_in,
  input wire logic pin_din_in,
  output fbdac_pkg::fbdac_pin_ovr_t ovr_out,
  output logic pin_din_out
);
  import fbdac_pkg::*;

  // routed pin loses driver, pull-up and detector
  always_comb begin
    ovr_out.driver_off = route_in; // RULE8
    ovr_out.pullup_off = route_in; // RULE8
    ovr_out.detector_off = route_in; // RULE8
    ovr_out.read_zero = route_in;
  end

  // digital read of a routed pin is forced low
  assign pin_din_out = route_in ? 1'b0 : pin_din_in; // RULE9
endmodule

// ===== src/fbdac_source_decode.sv
// decoding of the source selects into the analog mux controls
`timescale 1ns/1ps
`include "fbdac_map.svh"
module fbdac_source_decode (
  input fbdac_pkg::fbdac_ctrl_t ctrl_in,
  input wire logic [4:0] level_in,
  output fbdac_pkg::fbdac_analog_t analog_out
);
  import fbdac_pkg::*;

  // reserved positive code selects no source at all, so the ladder floats rather than shorting
  function automatic fbdac_pos_t pos_decode(input logic [1:0] sel);
    unique case (sel)
      `FBDAC_PSS_SUPPLY: pos_decode = FBDAC_POS_SUPPLY;
      `FBDAC_PSS_VREFP: pos_decode = FBDAC_POS_VREFP;
      `FBDAC_PSS_BUFFER: pos_decode = FBDAC_POS_BUFFER;
      default: pos_decode = FBDAC_POS_NONE;
    endcase
  endfunction

  always_comb begin
    analog_out.enable = ctrl_in.enable; // RULE1
    analog_out.pos_src = pos_decode(ctrl_in.positive_source_select); // RULE6
    analog_out.neg_vrefm = ctrl_in.negative_source_select; // RULE7
    analog_out.level_code = level_in; // RULE2
  end
endmodule

// ===== src/fbdac_top.sv
// five-bit converter control: ahb-lite register slave, analog controls and pin overrides
`timescale 1ns/1ps
`include "fbdac_map.svh"
module fbdac_top (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic pin_a_din_in,
  input wire logic pin_b_din_in,
  output logic pin_a_din_out,
  output logic pin_b_din_out,
  output fbdac_pkg::fbdac_pin_ovr_t pin_a_ovr_out,
  output fbdac_pkg::fbdac_pin_ovr_t pin_b_ovr_out,
  output fbdac_pkg::fbdac_analog_t analog_out,
  output logic analog_out_pin_a_out,
  output logic analog_out_pin_b_out
);
  import fbdac_pkg::*;

  fbdac_ctrl_t ctrl_q;
  logic [4:0] level_q;
  logic wr_pend_q;
  logic [`FBDAC_ADDR_W-1:0] wr_addr_q;
  logic [1:0] pin_a_sync_q;
  logic [1:0] pin_b_sync_q;
  logic pin_a_rd_d;
  logic pin_b_rd_d;
  fbdac_pin_ovr_t ovr_a_d;
  fbdac_pin_ovr_t ovr_b_d;
  fbdac_analog_t analog_d;
  logic [31:0] rdata_d;
  logic addr_phase;

  // packs the control register into its byte image, gaps read zero
  function automatic logic [7:0] ctrl_image(input fbdac_ctrl_t c);
    logic [7:0] v;
    v = 8'h00;
    v[`FBDAC_EN_BIT] = c.enable;
    v[`FBDAC_OEA_BIT] = c.pin_a_output_enable;
    v[`FBDAC_OEB_BIT] = c.pin_b_output_enable;
    v[`FBDAC_PSS_HI:`FBDAC_PSS_LO] = c.positive_source_select;
    v[`FBDAC_NSS_BIT] = c.negative_source_select;
    ctrl_image = v & `FBDAC_CTRL_MASK; // RULE12
  endfunction

  // read data for a word address, unmapped words read zero
  function automatic logic [31:0] read_word(input logic [`FBDAC_ADDR_W-1:0] a, input fbdac_ctrl_t c,
                                            input logic [4:0] lv);
    read_word = 32'h0000_0000;
    if (a == `FBDAC_CTRL_ADDR) begin
      read_word = {24'h00_0000, ctrl_image(c)};
    end else if (a == `FBDAC_LEVEL_ADDR) begin
      read_word = {27'h000_0000, lv}; // RULE12
    end
  endfunction

  assign addr_phase = hsel_in & hready_in & htrans_in[`FBDAC_HTRANS_NONSEQ_BIT];

  // write address is remembered for the data phase
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (hready_in) begin
      wr_pend_q <= addr_phase & hwrite_in;
      wr_addr_q <= haddr_in[`FBDAC_ADDR_W-1:0];
    end
  end

  // control register; only reset and bus writes change it, so sleep and wake leave it as written
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= '0; // RULE11
    end else if (wr_pend_q && wr_addr_q == `FBDAC_CTRL_ADDR) begin
      ctrl_q.enable <= hwdata_in[`FBDAC_EN_BIT]; // RULE1
      ctrl_q.pin_a_output_enable <= hwdata_in[`FBDAC_OEA_BIT]; // RULE4
      ctrl_q.pin_b_output_enable <= hwdata_in[`FBDAC_OEB_BIT]; // RULE5
      ctrl_q.positive_source_select <= hwdata_in[`FBDAC_PSS_HI:`FBDAC_PSS_LO]; // RULE6
      ctrl_q.negative_source_select <= hwdata_in[`FBDAC_NSS_BIT]; // RULE7
    end
  end // RULE10

  // level register, upper bits dropped on write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_q <= `FBDAC_LEVEL_RST; // RULE11
    end else if (wr_pend_q && wr_addr_q == `FBDAC_LEVEL_ADDR) begin
      level_q <= hwdata_in[4:0]; // RULE3
    end
  end

  // read data registered at the address phase, so it stands in the data phase
  assign rdata_d = read_word(haddr_in[`FBDAC_ADDR_W-1:0], ctrl_q, level_q);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (addr_phase && !hwrite_in) begin
      hrdata_out <= rdata_d;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // pad inputs come from outside: two flops before the override reads them
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_a_sync_q <= 2'h0;
      pin_b_sync_q <= 2'h0;
    end else begin
      pin_a_sync_q <= {pin_a_sync_q[0], pin_a_din_in};
      pin_b_sync_q <= {pin_b_sync_q[0], pin_b_din_in};
    end
  end

  fbdac_pin_override u_pin_a (
    .route_in(ctrl_q.pin_a_output_enable), // RULE4
    .pin_din_in(pin_a_sync_q[1]),
    .ovr_out(ovr_a_d),
    .pin_din_out(pin_a_rd_d)
  );

  fbdac_pin_override u_pin_b (
    .route_in(ctrl_q.pin_b_output_enable), // RULE5
    .pin_din_in(pin_b_sync_q[1]),
    .ovr_out(ovr_b_d),
    .pin_din_out(pin_b_rd_d)
  );

  fbdac_source_decode u_src (
    .ctrl_in(ctrl_q),
    .level_in(level_q),
    .analog_out(analog_d)
  );

  // outputs registered; one cycle after a write the pins and ladder follow
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_a_ovr_out <= fbdac_pin_ovr_t'(4'h0);
      pin_b_ovr_out <= fbdac_pin_ovr_t'(4'h0);
      pin_a_din_out <= 1'b0;
      pin_b_din_out <= 1'b0;
      analog_out <= fbdac_analog_t'(10'h000); // RULE11
      analog_out_pin_a_out <= 1'b0;
      analog_out_pin_b_out <= 1'b0;
    end else begin
      pin_a_ovr_out <= ovr_a_d; // RULE8
      pin_b_ovr_out <= ovr_b_d; // RULE8
      pin_a_din_out <= pin_a_rd_d; // RULE9
      pin_b_din_out <= pin_b_rd_d; // RULE9
      analog_out <= analog_d; // RULE2
      analog_out_pin_a_out <= ctrl_q.pin_a_output_enable; // RULE4
      analog_out_pin_b_out <= ctrl_q.pin_b_output_enable; // RULE5
    end
  end
endmodule

// ===== test/fbdac_top_asserts.sv
// port checks for the converter control block
`timescale 1ns/1ps
`include "fbdac_map.svh"
module fbdac_top_asserts (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire fbdac_pkg::fbdac_pin_ovr_t pin_a_ovr_out,
  input wire fbdac_pkg::fbdac_analog_t analog_out,
  input wire logic analog_out_pin_a_out,
  input wire logic analog_out_pin_b_out
);
  import fbdac_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // write taken at its address edge; the register loads one edge later
  sequence s_wr(a);
    hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in[13:0] == a ##1 1'b1;
  endsequence
  // outputs follow one edge after the register, so compare with data two edges back
  property p_en; s_wr(`FBDAC_CTRL_ADDR) |-> ##2 analog_out.enable == $past(hwdata_in[7], 2); endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_pa; s_wr(`FBDAC_CTRL_ADDR) |-> ##2 analog_out_pin_a_out == $past(hwdata_in[5], 2); endproperty
  a_pa: assert property (p_pa) else $error("pin a switch wrong");
  property p_pb; s_wr(`FBDAC_CTRL_ADDR) |-> ##2 analog_out_pin_b_out == $past(hwdata_in[4], 2); endproperty
  a_pb: assert property (p_pb) else $error("pin b switch wrong");
  property p_pos; s_wr(`FBDAC_CTRL_ADDR) |-> ##2 analog_out.pos_src == $past(hwdata_in[3:2], 2); endproperty
  a_pos: assert property (p_pos) else $error("positive source wrong");
  property p_neg; s_wr(`FBDAC_CTRL_ADDR) |-> ##2 analog_out.neg_vrefm == $past(hwdata_in[0], 2); endproperty
  a_neg: assert property (p_neg) else $error("negative source wrong");
  property p_lvl; s_wr(`FBDAC_LEVEL_ADDR) |-> ##2 analog_out.level_code == $past(hwdata_in[4:0], 2); endproperty
  a_lvl: assert property (p_lvl) else $error("level code wrong");
  // every override of pin a rides on its switch
  property p_ovr; pin_a_ovr_out == {4{analog_out_pin_a_out}}; endproperty
  a_ovr: assert property (p_ovr) else $error("pin a override wrong");
  // checked while reset is low, so the default disable is overridden
  property p_rst; disable iff (1'b0) !resetn_in |-> analog_out == '0 && !analog_out_pin_a_out && !analog_out_pin_b_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

bind fbdac_top fbdac_top_asserts chk_u (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .pin_a_ovr_out(pin_a_ovr_out), .analog_out(analog_out), .analog_out_pin_a_out(analog_out_pin_a_out),
  .analog_out_pin_b_out(analog_out_pin_b_out));

// ===== test/fbdac_top_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "fbdac_map.svh"
module fbdac_top_tb_top;
  import fbdac_pkg::*;
  logic clk, resetn, sel, wr, dina, dinb, rdy, resp, douta, doutb, swa, swb;
  logic [1:0] trans;
  logic [31:0] addr, wdata, rdata, r;
  fbdac_pin_ovr_t ova, ovb;
  fbdac_analog_t an;
  int errors, checked, cyc;
  // the slave's ready is the bus ready
  fbdac_top dut_u (.clk_in(clk), .resetn_in(resetn), .hsel_in(sel), .haddr_in(addr), .htrans_in(trans),
    .hwrite_in(wr), .hsize_in(3'h2), .hwdata_in(wdata), .hready_in(rdy), .hrdata_out(rdata),
    .hreadyout_out(rdy), .hresp_out(resp), .pin_a_din_in(dina), .pin_b_din_in(dinb), .pin_a_din_out(douta),
    .pin_b_din_out(doutb), .pin_a_ovr_out(ova), .pin_b_ovr_out(ovb), .analog_out(an),
    .analog_out_pin_a_out(swa), .analog_out_pin_b_out(swb));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task final_report;
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // a hang ends the run with a mismatch counted
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      final_report;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // one single transfer; each phase holds until ready is seen high
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1;
    addr <= a;
    trans <= 2'h2;
    wr <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    trans <= 2'h0;
    wdata <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    r = rdata;
  endtask
  // covers the register edge, the output edge and the pin synchroniser
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task t_clear;
    chk("analog", 0, an);
    chk("switches", 0, {swa, swb});
    chk("response", 0, resp);
    bus(0, `FBDAC_CTRL_ADDR, 0);
    chk("ctrl", 0, r);
    bus(0, `FBDAC_LEVEL_ADDR, 0);
    chk("level", 0, r);
  endtask
  // every source code and both pins each way, unused bits written as ones except bit 6 of 8'h9B
  task t_ctrl;
    logic [7:0] v[4] = '{8'hF3, 8'h66, 8'h9B, 8'h4E};
    foreach (v[i]) begin
      bus(1, `FBDAC_CTRL_ADDR, v[i]);
      settle;
      chk("enable", v[i][7], an.enable);
      chk("pin a", v[i][5], swa);
      chk("pin b", v[i][4], swb);
      chk("positive", v[i][3:2], an.pos_src);
      chk("negative", v[i][0], an.neg_vrefm);
      chk("override", {{4{v[i][5]}}, {4{v[i][4]}}}, {ova, ovb});
      bus(0, `FBDAC_CTRL_ADDR, 0);
      chk("ctrl read", v[i] & 8'hBD, r);
    end
  endtask
  // top code, a value that only touches unused bits, and a middle code
  task t_level;
    logic [7:0] v[3] = '{8'hFF, 8'h20, 8'h15};
    foreach (v[i]) begin
      bus(1, `FBDAC_LEVEL_ADDR, v[i]);
      settle;
      chk("code", v[i][4:0], an.level_code);
      bus(0, `FBDAC_LEVEL_ADDR, 0);
      chk("level read", v[i] & 8'h1F, r);
    end
  endtask
  task t_pins;
    dina <= 1;
    dinb <= 1;
    bus(1, `FBDAC_CTRL_ADDR, 8'h20);
    settle;
    chk("read a", 0, douta);
    chk("read b", 1, doutb);
    bus(1, `FBDAC_CTRL_ADDR, 8'h10);
    settle;
    chk("read a", 1, douta);
    chk("read b", 0, doutb);
  endtask
  // stray address must not disturb the control register, then a reset in mid-run
  task t_stray;
    bus(1, `FBDAC_CTRL_ADDR, 8'hB1);
    bus(1, 32'h3CD4, 8'hFF);
    bus(0, 32'h3CD4, 0);
    chk("unmapped", 0, r);
    bus(0, `FBDAC_CTRL_ADDR, 0);
    chk("ctrl kept", 8'hB1, r);
    @(posedge clk);
    resetn <= 0;
    @(posedge clk);
    resetn <= 1;
    t_clear;
  endtask
  initial begin
    resetn = 0;
    sel = 0;
    addr = 0;
    trans = 0;
    wr = 0;
    wdata = 0;
    dina = 0;
    dinb = 0;
    repeat (4) @(posedge clk);
    resetn <= 1;
    t_clear;
    t_ctrl;
    t_level;
    t_pins;
    t_stray;
    final_report;
  end
endmodule
